// ==== include/flop_ctrl_pkg.sv ====
package flop_ctrl_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int          ADDR_W          = 9;
	localparam int          DATA_W          = 8;
	localparam int          CHANNELS        = 4;
	localparam logic [8:0]  CH0_CTRL_ADDR   = 9'h183;
	localparam logic [8:0]  CH1_CTRL_ADDR   = 9'h193;
	localparam logic [8:0]  CH2_CTRL_ADDR   = 9'h1A3;
	localparam logic [8:0]  CH3_CTRL_ADDR   = 9'h1B3;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int          SEC_ACT_LSB     = 6;
	localparam int          CAP1_EN_BIT     = 5;
	localparam int          CAP0_EN_BIT     = 4;
	localparam int          CMP1_EN_BIT     = 3;
	localparam int          CMP0_EN_BIT     = 2;
	localparam int          PRI_ACT_LSB     = 0;

	// ----------------------------------------
	// Action encoding and reset values
	// ----------------------------------------
	localparam logic [1:0]  ACT_INVERT      = 2'h0;
	localparam logic [1:0]  ACT_SET         = 2'h1;
	localparam logic [1:0]  ACT_CLEAR       = 2'h2;
	localparam logic [1:0]  ACT_READBACK    = 2'h3;
	localparam logic [3:0]  ENABLES_RESET   = 4'h0;
	localparam logic        FLOP_RESET      = 1'b0;
endpackage : flop_ctrl_pkg

// ==== core/timer_output_flop_control.sv ====
// Local design decision: the strobed register port.
`timescale 1ns/100ps
// Behaviour
// R1 - Secondary action field: invert, set, clear, none.
// R2 - Primary action field: invert, set, clear, none.
// R3 - Both action fields always read back 11.
// R4 - Capture one load inverts primary when enabled.
// R5 - Capture zero load inverts primary when enabled.
// R6 - Compare one match inverts primary when enabled.
// R7 - Compare zero match inverts primary when enabled.
// R8 - Primary flop drives the timer output pin.
// R9 - Software uses plain writes, never read-modify-write.
// R10 - Actions apply once per write; flops hold otherwise, except that enabled events invert primary.
module timer_output_flop_control (
	input  wire logic                                ref_clk,
	input  wire logic                                sys_rst,
	input  wire logic [flop_ctrl_pkg::ADDR_W-1:0]    addr,
	input  wire logic [flop_ctrl_pkg::DATA_W-1:0]    wr_data,
	input  wire logic                                wr_strobe,
	input  wire logic                                rd_strobe,
	output logic      [flop_ctrl_pkg::DATA_W-1:0]    rd_data,
	input  wire logic [flop_ctrl_pkg::CHANNELS-1:0]  compare_zero_match,
	input  wire logic [flop_ctrl_pkg::CHANNELS-1:0]  compare_one_match,
	input  wire logic [flop_ctrl_pkg::CHANNELS-1:0]  capture_zero_load,
	input  wire logic [flop_ctrl_pkg::CHANNELS-1:0]  capture_one_load,
	output logic      [flop_ctrl_pkg::CHANNELS-1:0]  timer_output_pin,
	output logic      [flop_ctrl_pkg::CHANNELS-1:0]  secondary_output_flop
);
	import flop_ctrl_pkg::*;

	// ----------------------------------------
	// Write data fields
	// ----------------------------------------
	logic [1:0]           pri_act;
	logic [1:0]           sec_act;
	logic [3:0]           new_enables;
	logic                 pri_invert_req;
	logic                 pri_set_req;
	logic                 pri_clear_req;
	logic                 sec_invert_req;
	logic                 sec_set_req;
	logic                 sec_clear_req;

	assign pri_act     = wr_data[PRI_ACT_LSB+1:PRI_ACT_LSB];
	assign sec_act     = wr_data[SEC_ACT_LSB+1:SEC_ACT_LSB];
	assign new_enables = wr_data[CAP1_EN_BIT:CMP0_EN_BIT];

	always_comb begin
		pri_invert_req = 1'b0;
		pri_set_req    = 1'b0;
		pri_clear_req  = 1'b0;
		unique case (pri_act)
			ACT_INVERT: begin
				pri_invert_req = 1'b1; // R2
			end
			ACT_SET: begin
				pri_set_req = 1'b1; // R2
			end
			ACT_CLEAR: begin
				pri_clear_req = 1'b1; // R2
			end
			ACT_READBACK: begin
				pri_invert_req = 1'b0; // R10
			end
		endcase
	end

	always_comb begin
		sec_invert_req = 1'b0;
		sec_set_req    = 1'b0;
		sec_clear_req  = 1'b0;
		unique case (sec_act)
			ACT_INVERT: begin
				sec_invert_req = 1'b1; // R1
			end
			ACT_SET: begin
				sec_set_req = 1'b1; // R1
			end
			ACT_CLEAR: begin
				sec_clear_req = 1'b1; // R1
			end
			ACT_READBACK: begin
				sec_invert_req = 1'b0; // R10
			end
		endcase
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [CHANNELS-1:0]  sel;
	logic [CHANNELS-1:0]  wr_hit;
	logic [CHANNELS-1:0]  rd_hit;

	always_comb begin
		sel[0] = (addr == CH0_CTRL_ADDR);
		sel[1] = (addr == CH1_CTRL_ADDR);
		sel[2] = (addr == CH2_CTRL_ADDR);
		sel[3] = (addr == CH3_CTRL_ADDR);
	end

	assign wr_hit = sel & {CHANNELS{wr_strobe}};
	assign rd_hit = sel & {CHANNELS{rd_strobe}};

	// ----------------------------------------
	// Per-channel storage
	// ----------------------------------------
	localparam int        CAP1_IDX = CAP1_EN_BIT - CMP0_EN_BIT;
	localparam int        CAP0_IDX = CAP0_EN_BIT - CMP0_EN_BIT;
	localparam int        CMP1_IDX = CMP1_EN_BIT - CMP0_EN_BIT;
	localparam int        CMP0_IDX = CMP0_EN_BIT - CMP0_EN_BIT;

	wire  [CHANNELS-1:0]  primary_output_flop;
	wire  [CHANNELS-1:0]  secondary_flop_all;
	wire  [3:0]           enables_all [CHANNELS];

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
		logic  cap_one_en;
		logic  cap_zero_en;
		logic  cmp_one_en;
		logic  cmp_zero_en;
		logic  cap_one_hit;
		logic  cap_zero_hit;
		logic  cmp_one_hit;
		logic  cmp_zero_hit;
		logic  trig;
		logic  pri_set;
		logic  pri_clear;
		logic  pri_invert;
		logic  sec_set;
		logic  sec_clear;
		logic  sec_invert;
		logic  primary_q;
		logic  secondary_q;
		logic  next_primary;
		logic  next_secondary;

		// ----------------------------------------
		// Trigger enables
		// ----------------------------------------
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				cap_one_en <= ENABLES_RESET[CAP1_IDX];
			end else if (wr_hit[ch]) begin
				cap_one_en <= new_enables[CAP1_IDX]; // R4
			end
		end

		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				cap_zero_en <= ENABLES_RESET[CAP0_IDX];
			end else if (wr_hit[ch]) begin
				cap_zero_en <= new_enables[CAP0_IDX]; // R5
			end
		end

		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				cmp_one_en <= ENABLES_RESET[CMP1_IDX];
			end else if (wr_hit[ch]) begin
				cmp_one_en <= new_enables[CMP1_IDX]; // R6
			end
		end

		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				cmp_zero_en <= ENABLES_RESET[CMP0_IDX];
			end else if (wr_hit[ch]) begin
				cmp_zero_en <= new_enables[CMP0_IDX]; // R7
			end
		end

		// ----------------------------------------
		// Trigger events
		// ----------------------------------------
		always_comb begin
			cap_one_hit = 1'b0;
			if (cap_one_en) begin
				cap_one_hit = capture_one_load[ch]; // R4
			end
		end

		always_comb begin
			cap_zero_hit = 1'b0;
			if (cap_zero_en) begin
				cap_zero_hit = capture_zero_load[ch]; // R5
			end
		end

		always_comb begin
			cmp_one_hit = 1'b0;
			if (cmp_one_en) begin
				cmp_one_hit = compare_one_match[ch]; // R6
			end
		end

		always_comb begin
			cmp_zero_hit = 1'b0;
			if (cmp_zero_en) begin
				cmp_zero_hit = compare_zero_match[ch]; // R7
			end
		end

		// Simultaneous events in one cycle pair up, so an even count leaves the flop alone.
		assign trig = cap_one_hit ^ cap_zero_hit ^ cmp_one_hit ^ cmp_zero_hit;

		// ----------------------------------------
		// Write actions
		// ----------------------------------------
		assign pri_set    = wr_hit[ch] && pri_set_req; // R2
		assign pri_clear  = wr_hit[ch] && pri_clear_req; // R2
		assign pri_invert = wr_hit[ch] && pri_invert_req; // R2
		assign sec_set    = wr_hit[ch] && sec_set_req; // R1
		assign sec_clear  = wr_hit[ch] && sec_clear_req; // R1
		assign sec_invert = wr_hit[ch] && sec_invert_req; // R1

		// ----------------------------------------
		// Primary flop
		// ----------------------------------------
		// A set or clear write wins over a trigger event in the same cycle.
		always_comb begin
			next_primary = primary_q; // R10
			if (pri_set) begin
				next_primary = 1'b1; // R2
			end else if (pri_clear) begin
				next_primary = 1'b0; // R2
			end else if (trig ^ pri_invert) begin
				next_primary = ~primary_q; // R2
			end
		end

		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				primary_q <= FLOP_RESET;
			end else begin
				primary_q <= next_primary;
			end
		end

		// ----------------------------------------
		// Secondary flop
		// ----------------------------------------
		always_comb begin
			next_secondary = secondary_q; // R10
			if (sec_set) begin
				next_secondary = 1'b1; // R1
			end else if (sec_clear) begin
				next_secondary = 1'b0; // R1
			end else if (sec_invert) begin
				next_secondary = ~secondary_q; // R1
			end
		end

		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				secondary_q <= FLOP_RESET;
			end else begin
				secondary_q <= next_secondary;
			end
		end

		// ----------------------------------------
		// Channel outputs
		// ----------------------------------------
		assign primary_output_flop[ch] = primary_q; // R8
		assign secondary_flop_all[ch]  = secondary_q;
		assign enables_all[ch]         = {cap_one_en, cap_zero_en, cmp_one_en, cmp_zero_en};
	end

	assign timer_output_pin      = primary_output_flop; // R8
	assign secondary_output_flop = secondary_flop_all;

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Action fields read as a constant, so read-modify-write writes back the no-action code.
	logic [3:0]           rd_enables;
	logic [DATA_W-1:0]    next_rd_data;

	always_comb begin
		unique case (addr)
			CH0_CTRL_ADDR: begin
				rd_enables = enables_all[0];
			end
			CH1_CTRL_ADDR: begin
				rd_enables = enables_all[1];
			end
			CH2_CTRL_ADDR: begin
				rd_enables = enables_all[2];
			end
			CH3_CTRL_ADDR: begin
				rd_enables = enables_all[3];
			end
			default: begin
				rd_enables = ENABLES_RESET;
			end
		endcase
	end

	always_comb begin
		next_rd_data = '0;
		if (|rd_hit) begin
			next_rd_data = {ACT_READBACK, rd_enables, ACT_READBACK}; // R3
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= next_rd_data;
		end
	end
endmodule : timer_output_flop_control

// ==== dv/flop_props.sv ====
`timescale 1ns/100ps
module flop_props import flop_ctrl_pkg::*; (
	input wire logic ref_clk, sys_rst, wr_strobe, rd_strobe,
	input wire logic [8:0] addr,
	input wire logic [7:0] wr_data, rd_data,
	input wire logic [3:0] compare_zero_match, compare_one_match, capture_zero_load,
	input wire logic [3:0] capture_one_load, timer_output_pin, secondary_output_flop
);
	// Channel 0 stands for all four; the bench covers the others.
	wire w0 = wr_strobe && addr == CH0_CTRL_ADDR;
	wire [1:0] pa = wr_data[1:0];
	wire [1:0] sa = wr_data[7:6];
	wire ev = compare_zero_match[0] | compare_one_match[0] | capture_zero_load[0]
		| capture_one_load[0];
	wire p = timer_output_pin[0];
	wire s = secondary_output_flop[0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	pri_set_a: assert property (w0 && pa == 2'h1 |=> p) else $error("pri set");
	pri_clr_a: assert property (w0 && pa == 2'h2 |=> !p) else $error("pri clr");
	sec_set_a: assert property (w0 && sa == 2'h1 |=> s) else $error("sec set");
	sec_clr_a: assert property (w0 && sa == 2'h2 |=> !s) else $error("sec clr");
	sec_inv_a: assert property (w0 && sa == 2'h0 |=> s != $past(s)) else $error("sec inv");
	sec_hold_a: assert property (!(w0 && sa != 2'h3) |=> $stable(s)) else $error("sec");
	pri_hold_a: assert property (!w0 && !ev |=> $stable(p)) else $error("pri hold");
	read_back_a: assert property (rd_strobe && addr == CH0_CTRL_ADDR
		|=> &rd_data[7:6] && &rd_data[1:0]) else $error("rd");
	pri_inv_a: assert property (w0 && pa == 2'h0 && !ev
		|=> p != $past(p)) else $error("pri inv");
	rd_idle_a: assert property (!rd_strobe |=> rd_data == 8'h00) else $error("rd idle");
endmodule : flop_props
bind timer_output_flop_control flop_props i_props (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
	.addr(addr), .wr_data(wr_data), .rd_data(rd_data),
	.compare_zero_match(compare_zero_match), .compare_one_match(compare_one_match),
	.capture_zero_load(capture_zero_load), .capture_one_load(capture_one_load),
	.timer_output_pin(timer_output_pin), .secondary_output_flop(secondary_output_flop)
);

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench;
	logic ref_clk = 0, sys_rst = 1, wr_strobe = 0, rd_strobe = 0;
	logic [8:0] addr = 0;
	logic [7:0] wr_data = 0, rd_data;
	logic [15:0] ev = 0;
	logic [3:0] timer_output_pin, secondary_output_flop;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	// Row: addr, {wr,rd}, data, events, pins, secondary flops, read data.
	logic [55:0] rows [18] = '{56'h183_8_41_0000_1_1_00, 56'h193_8_C0_0000_3_1_00,
		56'h1A3_8_03_0000_3_5_00, 56'h183_8_82_0000_2_4_00, 56'h1B3_8_FF_0000_2_4_00,
		56'h183_8_C7_0000_2_4_00, 56'h000_0_00_000F_B_4_00, 56'h000_0_00_00F0_3_4_00,
		56'h000_0_00_0F00_B_4_00, 56'h000_0_00_F000_3_4_00, 56'h000_0_00_FFFF_2_4_00,
		56'h1B3_4_00_0000_2_4_FF, 56'h183_4_00_0000_2_4_C7, 56'h100_8_41_0000_2_4_00,
		56'h183_8_04_000F_A_5_00, 56'h183_8_C5_000F_3_5_00, 56'h100_4_00_0000_3_5_00,
		56'h183_8_3C_0000_2_4_00};
	timer_output_flop_control i_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
		.compare_zero_match(ev[3:0]), .compare_one_match(ev[7:4]),
		.capture_zero_load(ev[11:8]), .capture_one_load(ev[15:12]),
		.timer_output_pin(timer_output_pin), .secondary_output_flop(secondary_output_flop));
	always #10 ref_clk = ~ref_clk;
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task step(input logic [55:0] r);
		@(posedge ref_clk);
		addr <= r[52:44];
		{wr_strobe, rd_strobe} <= r[43:42];
		wr_data <= r[39:32];
		ev <= r[31:16];
		@(posedge ref_clk);
		{wr_strobe, rd_strobe} <= 2'b0;
		ev <= 16'h0;
		#1;
		chk("pin", {4'h0, r[15:12]}, {4'h0, timer_output_pin});
		chk("sec", {4'h0, r[11:8]}, {4'h0, secondary_output_flop});
		chk("rd", r[7:0], rd_data);
	endtask : step
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) step(rows[i]);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		step(56'h0);
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		step(56'h1B3_4_00_0000_0_0_C3);
		print_verdict();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 200) begin
			error_cnt++;
			print_verdict();
		end
	end
endmodule : testbench
